// [design/lfs_limit_flag_bank.sv]
/*
 * lfs_limit_flag_bank: configuration low byte and limit status
 * register, reached over a 16-bit serial frame.
 * assumes: sclk idles low (mode 0), csN frames each 16-bit access,
 * comparator events, busy and conversion results arrive on clk_sys.
 */
`timescale 1ns/100ps

// Summary of operation
// (RQ1) busy on flag pin needs bits 5 and 4
// (RQ2) bit 5 clear keeps busy off pin
// (RQ3) bit 4 picks output or flag, bit 3 level
// (RQ4) power-down field drives bias and reference
// (RQ5) sixteen bit read-only status, two per channel
// (RQ6) set only matching channel and direction flag
// (RQ7) flags accumulate until status is read
// (RQ8) reading status clears it
// (RQ9) clear lands on second clock of readout
// (RQ10) conversion result replaces pending status readout
// (RQ11) replaced readout leaves status flags intact
// (RQ12) missing channels always read zero
// (RQ13) channel n: high at 2n, low 2n+1
// (RQ14) status reads zero after reset
// (RQ15) host reads status after flag asserts
// (RQ16) software reinit clears status and result
// (RQ17) sticky bit picks clear by read or hysteresis
module lfs_limit_flag_bank
    import lfs_pkg::*;
#(
    parameter int NUM_CHAN = 8 // implemented channels: 2, 4 or 8
) (
    // system clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // serial link
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdi,
    output logic sdoOut,
    output logic sdoOe,
    // conversion engine side
    input wire lfs_limit_evt_t limitEvt,
    input wire logic hystClear,
    input wire logic convDone,
    input wire logic [15:0] convWord,
    input wire logic convBusy,
    // multifunction flag pin
    output logic flagPinOut,
    output logic flagPinOe,
    // general output and power control
    output logic gpo2Out,
    output logic biasOn,
    output logic refOn
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [4:0] bitCnt_reg;     // rising edges seen in this frame
    logic [15:0] rxShift_reg;   // incoming command bits
    lfs_cmd_t cmdWord_reg;      // last complete command
    logic cmdTgl_reg;           // flips once per complete command
    logic clrTgl_reg;           // flips at the readout clear edge
    logic outBit_reg;           // bit driven after a falling edge

    logic cmdSync;              // command toggle in system domain
    logic clrSync;              // clear toggle in system domain
    logic cmdSeen_reg;          // last command toggle acted on
    logic clrSeen_reg;          // last clear toggle acted on
    logic cmdEvt;               // one cycle: new command arrived
    logic clrEvt;               // one cycle: readout clear edge

    lfs_cfg_t cfg_reg;          // operating_configuration low byte
    logic [15:0] status_reg;    // limit_violation_status
    logic [15:0] txWord_reg;    // word shifted out next frame
    logic txIsStatus_reg;       // txWord holds a status snapshot
    logic alertActive_reg;      // flag condition before polarity

    logic [7:0] chanMask;       // implemented channels
    logic [15:0] flagMask;      // status bits that exist
    logic [15:0] setFlags;      // new flags this cycle
    logic reinit;               // software reinit write
    logic clrHit;               // readout clear applies to status
    logic cfgWrite;             // write to configuration
    logic [15:0] readMux;       // value of addressed register
    logic flagAct;              // flag pin active condition
    logic flagLevel;            // flag pin logic level

    // ------------------------------------------------------------
    // link domain: frame counter, ended by the frame's own select
    // ------------------------------------------------------------
    // counts rising edges; deselect returns it to zero
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            bitCnt_reg <= 5'h00;
        end else if (bitCnt_reg != FRAME_END) begin
            bitCnt_reg <= bitCnt_reg + 5'h01;
        end
    end

    // shift in the command, msb first
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            rxShift_reg <= 16'h0000;
        end else begin
            rxShift_reg <= {rxShift_reg[14:0], sdi};
        end
    end

    // latch the command on the sixteenth edge and signal it
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            cmdWord_reg <= '0;
            cmdTgl_reg <= 1'b0;
        end else if (!csN && bitCnt_reg == FRAME_END - 5'h01) begin
            cmdWord_reg <= lfs_cmd_t'({rxShift_reg[14:0], sdi});
            cmdTgl_reg <= ~cmdTgl_reg;
        end
    end

    // readout clear fires on the frame's second rising edge
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            clrTgl_reg <= 1'b0;
        end else if (!csN && bitCnt_reg == CLR_EDGE && txIsStatus_reg) begin
            clrTgl_reg <= ~clrTgl_reg; // [RQ9]
        end
    end

    // next data bit on each falling edge; txWord is loaded after command end,
    // but a conversion or reinit can replace it at any time, even mid-frame
    always_ff @(negedge sclk or negedge rstn) begin
        if (!rstn) begin
            outBit_reg <= 1'b0;
        end else if (bitCnt_reg < FRAME_END) begin
            outBit_reg <= txWord_reg[4'(4'hF - bitCnt_reg[3:0])];
        end else begin
            outBit_reg <= 1'b0;
        end
    end

    // msb shows as soon as the frame opens
    assign sdoOut = (bitCnt_reg == 5'h00) ? txWord_reg[15] : outBit_reg;
    assign sdoOe = ~csN;

    // ------------------------------------------------------------
    // crossings into the system domain
    // ------------------------------------------------------------
    lfs_sync3 cmdSyncer (
        .clk(clk_sys),
        .rstn(rstn),
        .asyncIn(cmdTgl_reg),
        .syncOut(cmdSync)
    );

    lfs_sync3 clrSyncer (
        .clk(clk_sys),
        .rstn(rstn),
        .asyncIn(clrTgl_reg),
        .syncOut(clrSync)
    );

    // remember toggles already acted on
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cmdSeen_reg <= 1'b0;
            clrSeen_reg <= 1'b0;
        end else begin
            cmdSeen_reg <= cmdSync;
            clrSeen_reg <= clrSync;
        end
    end

    assign cmdEvt = cmdSync ^ cmdSeen_reg;
    assign clrEvt = clrSync ^ clrSeen_reg;

    // ------------------------------------------------------------
    // decode and masks
    // ------------------------------------------------------------
    // channel mask from the implemented count
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            chanMask[n] = (n < NUM_CHAN);
        end
    end

    assign flagMask = lfsInterleave(chanMask, chanMask); // [RQ12]
    // only the matching channel and direction bit
    assign setFlags = lfsInterleave(limitEvt.overLimit, limitEvt.underLimit)
        & flagMask; // [RQ6] [RQ13]
    assign cfgWrite = cmdEvt && cmdWord_reg.write && cmdWord_reg.addr == CFG_ADDR;
    assign reinit = cfgWrite && cmdWord_reg.data[REINIT_BIT];
    assign clrHit = clrEvt && txIsStatus_reg; // [RQ11]

    // read value for the addressed register
    always_comb begin
        readMux = 16'h0000;
        if (cmdWord_reg.addr == CFG_ADDR) begin
            readMux = {8'h00, cfg_reg};
        end else if (cmdWord_reg.addr == STAT_ADDR) begin
            readMux = status_reg & flagMask; // [RQ5]
        end
    end

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    // reinit leaves configuration alone; bit 5 stored only with bit 4
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_reg <= lfs_cfg_t'(CFG_RESET); // [RQ4]
        end else if (cfgWrite && !reinit) begin
            cfg_reg <= lfs_cfg_t'(cmdWord_reg.data[7:0]);
            cfg_reg.busyEn <= cmdWord_reg.data[BUSY_BIT]
                & cmdWord_reg.data[ROLE_BIT]; // [RQ1]
        end
    end

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    // new flags win over the read clear and the reinit clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            status_reg <= STAT_RESET; // [RQ14]
        end else if (reinit) begin
            status_reg <= setFlags; // [RQ16]
        end else if (clrHit) begin
            // only bits held in the readout snapshot are cleared
            status_reg <= (status_reg & ~txWord_reg) | setFlags; // [RQ8]
        end else begin
            status_reg <= status_reg | setFlags; // [RQ7]
        end
    end

    // ------------------------------------------------------------
    // readout word
    // ------------------------------------------------------------
    // a conversion beats any pending register read
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txWord_reg <= 16'h0000;
            txIsStatus_reg <= 1'b0;
        end else if (reinit) begin
            txWord_reg <= 16'h0000; // [RQ16]
            txIsStatus_reg <= 1'b0;
        end else if (convDone) begin
            txWord_reg <= convWord; // [RQ10]
            txIsStatus_reg <= 1'b0; // [RQ11]
        end else if (cmdEvt && !cmdWord_reg.write) begin
            txWord_reg <= readMux;
            txIsStatus_reg <= (cmdWord_reg.addr == STAT_ADDR);
        end else if (clrHit) begin
            txIsStatus_reg <= 1'b0; // one clear per readout
        end
    end

    // ------------------------------------------------------------
    // flag condition
    // ------------------------------------------------------------
    // sticky keeps it until read or reinit; else hysteresis clears
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            alertActive_reg <= 1'b0;
        end else if (|setFlags) begin
            alertActive_reg <= 1'b1;
        end else if (reinit || clrHit || (!cfg_reg.sticky && hystClear)) begin
            alertActive_reg <= 1'b0; // [RQ17]
        end
    end

    // ------------------------------------------------------------
    // multifunction pin
    // ------------------------------------------------------------
    // busy only with both bits, flag otherwise, output when role 0
    assign flagAct = cfg_reg.busyEn ? convBusy : alertActive_reg; // [RQ1] [RQ2]
    assign flagLevel = cfg_reg.pinRole ? (flagAct ~^ cfg_reg.pinLevel)
        : cfg_reg.pinLevel; // [RQ3]

    // push-pull drives both levels, open-drain only pulls low
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flagPinOut <= 1'b0;
            flagPinOe <= 1'b0;
        end else if (cfg_reg.driveType) begin
            flagPinOut <= flagLevel;
            flagPinOe <= 1'b1;
        end else begin
            flagPinOut <= 1'b0;
            flagPinOe <= ~flagLevel;
        end
    end

    // ------------------------------------------------------------
    // general output and power-down decode
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gpo2Out <= 1'b0;
            biasOn <= 1'b0;
            refOn <= 1'b0;
        end else begin
            gpo2Out <= cfg_reg.gpo2;
            biasOn <= cfg_reg.pd[1]; // [RQ4]
            refOn <= (cfg_reg.pd == PD_REF_ON); // [RQ4]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // busy bit never stored without the role bit
    property p_busyNeedsRole;
        cfg_reg.busyEn |-> cfg_reg.pinRole;
    endproperty
    a_busyNeedsRole: assert property (p_busyNeedsRole) // [RQ1]
        else $error("busy set without pin role");

    // general output follows level bit, push-pull
    property p_gpoLevel;
        (!cfg_reg.pinRole && cfg_reg.driveType) |=> flagPinOut == $past(cfg_reg.pinLevel);
    endproperty
    a_gpoLevel: assert property (p_gpoLevel) // [RQ3]
        else $error("general output level wrong");

    // mode zero turns bias and reference off
    property p_pdOff;
        (cfg_reg.pd == PD_ALL_OFF) |=> (!biasOn && !refOn);
    endproperty
    a_pdOff: assert property (p_pdOff) // [RQ4]
        else $error("power-down mode zero not off");

    // an event sets its own bit next cycle
    property p_flagSet;
        (|setFlags) |=> ((status_reg & $past(setFlags)) == $past(setFlags));
    endproperty
    a_flagSet: assert property (p_flagSet) // [RQ6]
        else $error("limit event not recorded");

    // without a clear no flag is lost
    property p_accumulate;
        (!clrHit && !reinit) |=> ((status_reg & $past(status_reg)) == $past(status_reg));
    endproperty
    a_accumulate: assert property (p_accumulate) // [RQ7]
        else $error("status flag lost");

    // readout clear removes the shifted bits
    property p_readClear;
        (clrHit && !reinit && setFlags == 16'h0000)
            |=> ((status_reg & $past(txWord_reg)) == 16'h0000);
    endproperty
    a_readClear: assert property (p_readClear) // [RQ8]
        else $error("status not cleared by readout");

    // conversion result takes the readout slot
    property p_convWins;
        (convDone && !reinit) |=> (txWord_reg == $past(convWord) && !txIsStatus_reg);
    endproperty
    a_convWins: assert property (p_convWins) // [RQ10]
        else $error("conversion did not replace readout");

    // missing channels stay zero
    property p_unusedZero;
        (status_reg & ~flagMask) == 16'h0000;
    endproperty
    a_unusedZero: assert property (p_unusedZero) // [RQ12]
        else $error("unimplemented channel flag set");

    // reinit empties status when nothing new arrives
    property p_reinitClear;
        (reinit && setFlags == 16'h0000) |=> status_reg == 16'h0000;
    endproperty
    a_reinitClear: assert property (p_reinitClear) // [RQ16]
        else $error("reinit left status set");

    // sticky flag survives hysteresis
    property p_sticky;
        (cfg_reg.sticky && alertActive_reg && !reinit && !clrHit) |=> alertActive_reg;
    endproperty
    a_sticky: assert property (p_sticky) // [RQ17]
        else $error("sticky flag dropped");

    // clear toggle moves only at the second edge
    property p_clrEdge;
        @(posedge sclk) disable iff (!rstn)
        (clrTgl_reg != $past(clrTgl_reg)) |-> bitCnt_reg == 5'h02;
    endproperty
    a_clrEdge: assert property (p_clrEdge) // [RQ9]
        else $error("status clear at wrong edge");

    c_readClear: cover property (clrHit);
    c_convOverride: cover property (txIsStatus_reg && convDone);
    c_reinit: cover property (reinit && status_reg != 16'h0000);

endmodule // lfs_limit_flag_bank

// [design/lfs_pkg.sv]
/*
 * lfs_pkg: constants, carriers and helpers for the limit flag bank.
 * assumes: imported by lfs_limit_flag_bank and the bench before use; lfs_sync3 does not use it.
 */
package lfs_pkg;

    // ------------------------------------------------------------
    // serial frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;           // bits in one frame
    localparam logic [4:0] FRAME_END = 5'h10; // count after last edge
    localparam logic [4:0] CLR_EDGE = 5'h01;  // count before 2nd edge
    localparam int ADDR_MSB = 15;             // address field top
    localparam int ADDR_LSB = 11;             // address field bottom
    localparam int WRITE_BIT = 10;            // 1 = write command

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [4:0] CFG_ADDR = 5'h02;  // operating_configuration
    localparam logic [4:0] STAT_ADDR = 5'h07; // limit_violation_status

    // ------------------------------------------------------------
    // configuration fields and reset values
    // ------------------------------------------------------------
    localparam int REINIT_BIT = 9;            // software_reinit
    localparam int ROLE_BIT = 4;              // flag_pin_role_select
    localparam int BUSY_BIT = 5;              // busy indication on pin
    localparam logic [7:0] CFG_RESET = 8'hC0; // sticky=1, push-pull=1
    localparam logic [15:0] STAT_RESET = 16'h0000;
    localparam logic [1:0] PD_ALL_OFF = 2'h0; // bias off, reference off
    localparam logic [1:0] PD_REF_ON = 2'h1;  // reference on only

    // low configuration byte
    typedef struct packed {
        logic sticky;       // flag only clears on read or reinit
        logic driveType;    // 1 push-pull, 0 open-drain
        logic busyEn;       // busy shown on flag pin
        logic pinRole;      // 1 limit flag, 0 general output
        logic pinLevel;     // flag polarity or first_general_output
        logic gpo2;         // second_general_output_value
        logic [1:0] pd;     // power-down mode
    } lfs_cfg_t;

    // per channel limit events from the comparators
    typedef struct packed {
        logic [7:0] overLimit;   // high limit crossed, one per channel
        logic [7:0] underLimit;  // low limit crossed, one per channel
    } lfs_limit_evt_t;

    // one received command frame
    typedef struct packed {
        logic [4:0] addr;   // register address
        logic write;        // 1 write, 0 read
        logic [9:0] data;   // write data
    } lfs_cmd_t;

    // place over flag at bit 2n and under flag at bit 2n+1
    function automatic logic [15:0] lfsInterleave(logic [7:0] hi, logic [7:0] lo);
        logic [15:0] r;
        r = 16'h0000;
        for (int n = 0; n < 8; n++) begin
            r[2*n] = hi[n];
            r[2*n+1] = lo[n];
        end
        return r;
    endfunction

endpackage

// [design/lfs_sync3.sv]
/*
 * lfs_sync3: three flop synchroniser for a single level.
 * assumes: input is asynchronous to clk; output updates only when
 * the second and third stage agree.
 */
`timescale 1ns/100ps
module lfs_sync3 (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // level in and out
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_reg; // metastable stage, read only by stage2
    logic stage2_reg; // first settled stage
    logic stage3_reg; // agreement stage

    // ------------------------------------------------------------
    // shift chain
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // output follows once two settled stages agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncOut <= 1'b0;
        end else if (stage2_reg == stage3_reg) begin
            syncOut <= stage3_reg;
        end
    end

endmodule // lfs_sync3

// [test/lfs_spi_host.sv]
/*
 * lfs_spi_host: behavioural host controller for the serial link.
 * assumes: mode 0 framing, sclk idles low outside frames, caller
 * spaces frames itself only through the gap built into xfer.
 */
`timescale 1ns/100ps
module lfs_spi_host #(
    parameter real HALF = 6.0 // half of the 12 ns link period
) (
    // link outputs toward the device
    output logic sclk,
    output logic csN,
    output logic sdi,
    // data back from the device
    input wire logic sdo
);
    // ------------------------------------------------------------
    // idle state
    // ------------------------------------------------------------
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end

    // one 16-bit frame, msb first, with the idle gap after it
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        csN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = tx[i];   // set up before the rising edge
            #HALF;
            rx[i] = sdo;   // sample just before the rising edge
            sclk = 1'b1;
            #HALF;
            sclk = 1'b0;
        end
        #HALF;
        csN = 1'b1;
        sdi = ~sdi;        // released line must not look held
        #48;               // at least ten system cycles between frames
    endtask
endmodule // lfs_spi_host

// [test/test_lfs_limit_flag_bank.sv]
/*
 * test_lfs_limit_flag_bank: self-checking bench of the flag bank.
 * assumes: the host model owns the link, the bench owns the rest.
 */
`timescale 1ns/100ps
module test_lfs_limit_flag_bank;
    import lfs_pkg::*;
    // ------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------
    logic clk_sys = 1'b0, rstn = 1'b1, hystClear = 1'b0, convDone = 1'b0, convBusy = 1'b0;
    logic sclk, csN, sdi, sdoOut, sdoOe, flagPinOut, flagPinOe, gpo2Out, biasOn, refOn, sdo2;
    lfs_limit_evt_t limitEvt = '0;
    logic [15:0] convWord = 16'h0000, d, acc, d2;
    logic [31:0] seed = 32'h0000_001B; // xorshift start value 27
    logic [7:0] c;
    int errCount = 0, totalChecks = 0;

    always #2 clk_sys = ~clk_sys; // 250 MHz

    lfs_limit_flag_bank dut (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .csN(csN),
        .sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe), .limitEvt(limitEvt),
        .hystClear(hystClear), .convDone(convDone), .convWord(convWord),
        .convBusy(convBusy), .flagPinOut(flagPinOut), .flagPinOe(flagPinOe),
        .gpo2Out(gpo2Out), .biasOn(biasOn), .refOn(refOn));
    lfs_spi_host host (.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdoOe ? sdoOut : 1'bz));
    // two-channel variant on the same link, only its readout is watched
    lfs_limit_flag_bank #(.NUM_CHAN(2)) dut2 (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk),
        .csN(csN), .sdi(sdi), .sdoOut(sdo2), .sdoOe(), .limitEvt(limitEvt),
        .hystClear(hystClear), .convDone(convDone), .convWord(convWord),
        .convBusy(convBusy), .flagPinOut(), .flagPinOe(), .gpo2Out(), .biasOn(),
        .refOn());
    // capture its readout bit at each rising link edge
    always @(posedge sclk)
        if (!csN) d2 <= {d2[14:0], sdo2};

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // expected status layout: pair {under, over} per channel
    function automatic logic [15:0] expStat(input logic [15:0] e);
        logic [15:0] r;
        for (int n = 0; n < 8; n++) r[2*n +: 2] = {e[n], e[n+8]};
        return r;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // register read: command frame, then a frame for the data
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        host.xfer({a, 11'h000}, v);
        host.xfer(16'h0000, v);
    endtask
    task automatic wr(input logic [4:0] a, input logic [9:0] v);
        host.xfer({a, 1'b1, v}, d);
    endtask
    // one-cycle pulses on the engine side, then let them land
    task automatic pulse(input logic [15:0] e, input logic h, input logic cd);
        @(negedge clk_sys);
        limitEvt = e;
        hystClear = h;
        convDone = cd;
        @(negedge clk_sys);
        limitEvt = '0;
        hystClear = 1'b0;
        convDone = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog, far beyond the expected 7.5 us of traffic
    initial begin
        #100us;
        errCount++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        #1 rstn = 1'b0; // a real falling edge resets the link domain too
        #12 rstn = 1'b1;
        repeat (2) @(negedge clk_sys);
        rd(STAT_ADDR, d);
        chk(d, STAT_RESET);
        rd(CFG_ADDR, d);
        chk(d, {8'h00, CFG_RESET});
        $display("reset values done");
        // channel 7 both ways plus random single events
        acc = 16'h8080;
        pulse(acc, 1'b0, 1'b0);
        for (int k = 0; k < 5; k++) begin
            seed = xs(seed);
            pulse(16'h0001 << seed[3:0], 1'b0, 1'b0);
            acc |= 16'h0001 << seed[3:0];
        end
        wr(STAT_ADDR, 10'h3FF); // writes to status are ignored
        rd(STAT_ADDR, d); // host asks which channel raised the flag
        chk(d, expStat(acc));
        chk(d2, expStat(acc) & 16'h000F);
        rd(STAT_ADDR, d);
        chk(d, 16'h0000);
        $display("accumulate and clear done");
        // conversion lands between command and readout
        pulse(16'h0100, 1'b0, 1'b0);
        seed = xs(seed);
        @(negedge clk_sys);
        convWord = seed[31:16];
        host.xfer({STAT_ADDR, 11'h000}, d);
        pulse(16'h0000, 1'b0, 1'b1);
        host.xfer(16'h0000, d);
        chk(d, seed[31:16]);
        rd(STAT_ADDR, d);
        chk(d, 16'h0001);
        $display("conversion override done");
        // general output role, every power-down code
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            c = {1'b1, k[1], 2'b00, seed[3:2], k[1:0]}; // open-drain for codes 0 and 1
            wr(CFG_ADDR, {2'b00, c});
            chk({11'h000, flagPinOut, flagPinOe, gpo2Out, biasOn, refOn},
                {11'h000, c[6] & c[3], c[6] | ~c[3], c[2], c[1],
                c[1:0] == PD_REF_ON});
        end
        // busy shown on pin only with role and busy bits set
        wr(CFG_ADDR, 10'h0F8);
        @(negedge clk_sys);
        convBusy = 1'b1;
        pulse(16'h0000, 1'b0, 1'b0);
        chk({15'h0000, flagPinOut}, 16'h0001);
        wr(CFG_ADDR, 10'h0E0);
        rd(CFG_ADDR, d);
        chk(d, 16'h00C0);
        wr(CFG_ADDR, 10'h0D8);
        chk({15'h0000, flagPinOut}, 16'h0000);
        @(negedge clk_sys);
        convBusy = 1'b0;
        $display("pin roles done");
        // hysteresis clear only when not sticky
        for (int k = 0; k < 2; k++) begin
            wr(CFG_ADDR, {2'b00, k[0], 7'h58});
            pulse(16'h0002, 1'b0, 1'b0);
            chk({15'h0000, flagPinOut}, 16'h0001);
            pulse(16'h0000, 1'b1, 1'b0);
            chk({15'h0000, flagPinOut}, {15'h0000, k[0]});
        end
        wr(CFG_ADDR, 10'h200);
        chk({15'h0000, flagPinOut}, 16'h0000);
        rd(STAT_ADDR, d);
        chk(d, 16'h0000);
        rd(CFG_ADDR, d);
        chk(d, 16'h00D8);
        $display("sticky and reinit done");
        end_of_test();
    end
endmodule // test_lfs_limit_flag_bank
